// ---- hw/pssa_phys_reg.v ----
// One 80-bit physical floating-point register with its 2-bit tag.
// Assumes a single clock and asynchronous active-low reset.
`timescale 1ns/100ps
`include "pssa_regs.vh"

module pssa_phys_reg #(
  parameter W = 80                  // Physical register width
) (
  hclk,
  hresetn,
  wr_fp,
  wr_simd,
  fp_data,
  simd_data,
  tag_wr,
  tag_data,
  q,
  tag_q
);
  input  wire          hclk;        // Processor clock
  input  wire          hresetn;     // Async reset, active low
  input  wire          wr_fp;       // Full-width float write
  input  wire          wr_simd;     // Low-64 write from SIMD side
  input  wire [W-1:0]  fp_data;     // Float write data
  input  wire [63:0]   simd_data;   // SIMD write data
  input  wire          tag_wr;      // Tag update strobe
  input  wire [1:0]    tag_data;    // New tag
  output reg  [W-1:0]  q;           // Stored value
  output reg  [1:0]    tag_q;       // Stored tag

  // ----------------------------------------------------------------
  // Storage shared by both views
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q     <= {W{1'b0}};
      tag_q <= `PSSA_TAG_EMPTY;
    end else begin
      if (wr_simd) begin
        q <= {`PSSA_EXP_ONES, simd_data}; // Exponent forced to ones
      end else if (wr_fp) begin
        q <= fp_data;                     // Float write as given
      end
      if (tag_wr) begin
        tag_q <= tag_data;
      end
    end
  end
endmodule

// ---- hw/pssa_regs.vh ----
// Constants for the packed-SIMD / floating-point state alias block.
// Assumes inclusion by the design files by bare name.
`ifndef PSSA_REGS_VH
`define PSSA_REGS_VH

// ------------------------------------------------------------------
// Register offsets (byte addresses on the AHB-Lite slave)
// ------------------------------------------------------------------
`define PSSA_OFF_CTRL      8'h00
`define PSSA_OFF_STATUS    8'h04
`define PSSA_OFF_TAGW      8'h08
`define PSSA_OFF_FPSW      8'h0C
`define PSSA_OFF_IRQ_STAT  8'h10
`define PSSA_OFF_IRQ_EN    8'h14
`define PSSA_OFF_IRQ_CLR   8'h18
`define PSSA_OFF_PEND_SET  8'h1C
`define PSSA_OFF_FEATURE   8'h20

// ------------------------------------------------------------------
// Field positions and values
// ------------------------------------------------------------------
`define PSSA_CTRL_EMUL_BIT    2
`define PSSA_CTRL_NE_BIT      5
`define PSSA_FEAT_SIMD_BIT    23
`define PSSA_FEAT_LEAF        32'h00000001
`define PSSA_TAG_VALID        2'h0
`define PSSA_TAG_EMPTY        2'h3
`define PSSA_EXP_ONES         16'hFFFF
`define PSSA_TOP_W            3
`define PSSA_FPSW_TOP_LSB     11
`define PSSA_CTRL_RESET       32'h00000000
`define PSSA_TAGW_RESET       16'hFFFF

// ------------------------------------------------------------------
// Fault codes on the fault output
// ------------------------------------------------------------------
`define PSSA_FLT_NONE     3'h0
`define PSSA_FLT_UD       3'h1
`define PSSA_FLT_NUMERIC  3'h2
`define PSSA_FLT_MEM      3'h3

// ------------------------------------------------------------------
// Interrupt status bit positions
// ------------------------------------------------------------------
`define PSSA_IRQ_UD       0
`define PSSA_IRQ_NUM      1
`define PSSA_IRQ_MEM      2
`define PSSA_IRQ_EMPTY    3

// ------------------------------------------------------------------
// Numeric error vector
// ------------------------------------------------------------------
`define PSSA_NUM_VECTOR   8'h10

`endif

// ---- hw/pssa_top.v ----
// Packed-SIMD / floating-point state alias, fault and feature logic.
// Assumes the issue stage holds an op until op_ready; AHB-Lite slave.
//
// What this block does
// - No query op support raises invalid opcode
// - Query leaf 01H returns SIMD flag bit 23
// - Invalid opcode if unsupported or emulation set
// - SIMD op forces stack top to zero
// - SIMD op marks all tags valid
// - SIMD register write fills exponent ones
// - Empty-state op marks all tags empty instead
// - Empty tag encoding is binary 11
// - Float ops use state without adjustment
// - Memory faults reported like other instructions
// - SIMD ops raise no numeric fault themselves
// - Pending float fault reported via vector 16
// - SIMD op completes after handler returns
// - SIMD registers share float register storage
// - State-save ops store the SIMD contents
//
// The AHB-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "pssa_regs.vh"

module pssa_top #(
  parameter HAS_QUERY = 1,          // Feature-query op implemented
  parameter HAS_SIMD  = 1,          // Packed-SIMD implemented
  parameter NREG      = 8,          // Physical register count
  parameter RW        = 80          // Physical register width
) (
  hclk,
  hresetn,
  hsel,
  haddr,
  htrans,
  hwrite,
  hsize,
  hwdata,
  hready,
  hrdata,
  hreadyout,
  hresp,
  op_valid,
  op_kind,
  op_dst,
  op_wr_dst,
  op_data,
  op_leaf,
  op_supported,
  op_mem_fault,
  op_ready,
  op_fault,
  op_vector,
  op_result,
  handler_ret,
  save_idx,
  save_data,
  save_tag,
  fp_error_pin,
  irq
);
  // Op kinds presented by the issue stage
  localparam K_SIMD  = 3'h0;        // Packed-SIMD op
  localparam K_EMPTY = 3'h1;        // Empty-state op
  localparam K_QUERY = 3'h2;        // Feature-query op
  localparam K_FP    = 3'h3;        // Float op writing a register
  localparam K_SAVE  = 3'h4;        // State-save op (either form)
  // Issue state machine
  localparam S_RUN   = 1'b0;        // Taking ops
  localparam S_WAIT  = 1'b1;        // Waiting for handler return

  input  wire          hclk;        // Processor clock, 25 MHz
  input  wire          hresetn;     // Async reset, active low
  input  wire          hsel;        // Slave select
  input  wire [7:0]    haddr;       // Byte address
  input  wire [1:0]    htrans;      // Transfer type
  input  wire          hwrite;      // Write strobe
  input  wire [2:0]    hsize;       // Transfer size
  input  wire [31:0]   hwdata;      // Write data
  input  wire          hready;      // Bus ready in
  output reg  [31:0]   hrdata;      // Read data
  output wire          hreadyout;   // Always ready
  output wire          hresp;       // Always OKAY
  input  wire          op_valid;    // Op presented
  input  wire [2:0]    op_kind;     // Op class
  input  wire [2:0]    op_dst;      // Destination register
  input  wire          op_wr_dst;   // Op writes destination
  input  wire [79:0]   op_data;     // Result data
  input  wire [31:0]   op_leaf;     // Query leaf
  input  wire          op_supported;// Opcode known to this core
  input  wire          op_mem_fault;// Address unit flagged a fault
  output wire          op_ready;    // Op retired or faulted
  output reg  [2:0]    op_fault;    // Fault code of last op
  output reg  [7:0]    op_vector;   // Vector of last numeric fault
  output reg  [31:0]   op_result;   // Query result
  input  wire          handler_ret; // Numeric handler returned
  input  wire [2:0]    save_idx;    // Register read index for save
  output wire [79:0]   save_data;   // Saved register contents
  output wire [1:0]    save_tag;    // Saved tag
  output reg           fp_error_pin;// Numeric error pin, high
  output wire          irq;         // Level interrupt

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg  [31:0]          ctrl_reg;    // Control, emulation bit at 2
  reg  [2:0]           top_reg;     // Stack top pointer
  reg  [5:0]           fpsw_lo_reg; // Low status bits, bit0..5
  reg                  pend_reg;    // Pending float exception
  reg                  state_reg;   // Issue state
  reg  [3:0]           irq_st_reg;  // Sticky events
  reg  [3:0]           irq_en_reg;  // Interrupt enables
  reg                  last_simd_reg; // Last op was SIMD
  wire [RW*NREG-1:0]   reg_q;       // Flattened register file
  wire [2*NREG-1:0]    tag_q;       // Flattened tags
  wire [2*NREG-1:0]    tagw;        // Tag word

  // ----------------------------------------------------------------
  // Bus address phase capture
  // ----------------------------------------------------------------
  reg                  bus_wr_reg;  // Write data phase pending
  reg                  bus_rd_reg;  // Read data phase pending
  reg  [7:0]           bus_addr_reg;// Captured address
  wire                 bus_go;      // Valid address phase

  assign bus_go    = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_wr_reg   <= 1'b0;
      bus_rd_reg   <= 1'b0;
      bus_addr_reg <= 8'h00;
    end else begin
      bus_wr_reg <= bus_go & hwrite;
      bus_rd_reg <= bus_go & ~hwrite;
      if (bus_go) begin
        bus_addr_reg <= haddr;
      end
    end
  end

  // ----------------------------------------------------------------
  // Op decode
  // ----------------------------------------------------------------
  wire emul     = ctrl_reg[`PSSA_CTRL_EMUL_BIT];
  wire is_simd  = (op_kind == K_SIMD) | (op_kind == K_EMPTY);
  wire take     = op_valid & (state_reg == S_RUN);
  // Undefined-op fault conditions
  wire ud_query = (op_kind == K_QUERY) & (HAS_QUERY == 0);
  wire ud_simd  = is_simd & ((HAS_SIMD == 0) | ~op_supported | emul);
  wire ud       = ud_query | ud_simd;
  // Memory faults share the ordinary fault path
  wire mem_f    = ~ud & op_mem_fault;
  // Numeric fault only from a pending float exception
  wire num_f    = ~ud & ~mem_f & is_simd & pend_reg;
  wire retire   = take & ~ud & ~mem_f & ~num_f;
  wire simd_ret = retire & (op_kind == K_SIMD);
  wire empty_ret= retire & (op_kind == K_EMPTY);
  wire fp_ret   = retire & (op_kind == K_FP);

  assign op_ready = take;

  // ----------------------------------------------------------------
  // Issue state: hold faulting SIMD op until handler returns
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= S_RUN;
    end else begin
      case (state_reg)
        S_RUN: begin
          if (take & num_f) begin
            state_reg <= S_WAIT;
          end
        end
        default: begin
          if (handler_ret) begin
            state_reg <= S_RUN;          // Re-issue and complete
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Fault reporting and query result
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_fault     <= `PSSA_FLT_NONE;
      op_vector    <= 8'h00;
      op_result    <= 32'h00000000;
      fp_error_pin <= 1'b0;
    end else begin
      if (take) begin
        if (ud) begin
          op_fault <= `PSSA_FLT_UD;
        end else if (mem_f) begin
          op_fault <= `PSSA_FLT_MEM;
        end else if (num_f) begin
          op_fault  <= `PSSA_FLT_NUMERIC;
          op_vector <= `PSSA_NUM_VECTOR;
        end else begin
          op_fault <= `PSSA_FLT_NONE;
        end
        if (retire & (op_kind == K_QUERY)) begin
          op_result <= 32'h00000000;
          if (op_leaf == `PSSA_FEAT_LEAF) begin
            op_result[`PSSA_FEAT_SIMD_BIT] <= (HAS_SIMD != 0);
          end
        end
      end
      // Error pin high from report until handler return
      if (take & num_f) begin
        fp_error_pin <= 1'b1;
      end else if (handler_ret) begin
        fp_error_pin <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Stack top, pending flag, status word
  // ----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      top_reg       <= 3'h0;
      pend_reg      <= 1'b0;
      fpsw_lo_reg   <= 6'h00;
      last_simd_reg <= 1'b0;
    end else begin
      if (simd_ret) begin
        top_reg <= 3'h0;
      end else if (bus_wr_reg & (bus_addr_reg == `PSSA_OFF_FPSW)) begin
        top_reg <= hwdata[`PSSA_FPSW_TOP_LSB +: `PSSA_TOP_W];
      end
      // Set from bus wins over handler clear
      if (bus_wr_reg & (bus_addr_reg == `PSSA_OFF_PEND_SET) & hwdata[0]) begin
        pend_reg <= 1'b1;
      end else if (handler_ret & (state_reg == S_WAIT)) begin
        pend_reg <= 1'b0;
      end
      if (bus_wr_reg & (bus_addr_reg == `PSSA_OFF_FPSW)) begin
        fpsw_lo_reg <= hwdata[5:0];
      end
      if (retire) begin
        last_simd_reg <= (op_kind == K_SIMD);
      end
    end
  end

  // ----------------------------------------------------------------
  // Shared physical register file
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi = gi + 1) begin : g_reg
      localparam [2:0] IDX = gi;    // Register index at op width
      wire hit = (op_dst == IDX) & op_wr_dst;
      // SIMD register i is low 64 of physical register i
      pssa_phys_reg #(
        .W (RW)
      ) u_reg (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .wr_fp     (fp_ret & hit),
        .wr_simd   (simd_ret & hit),
        .fp_data   (op_data[RW-1:0]),
        .simd_data (op_data[63:0]),
        .tag_wr    (simd_ret | empty_ret | (fp_ret & hit)),
        .tag_data  (empty_ret ? `PSSA_TAG_EMPTY :
                    `PSSA_TAG_VALID),
        .q         (reg_q[gi*RW +: RW]),
        .tag_q     (tag_q[gi*2 +: 2])
      );
    end
  endgenerate
  assign tagw = tag_q;

  // Save port sees the shared storage, SIMD data included
  assign save_data = reg_q[save_idx*RW +: RW];
  assign save_tag  = tag_q[save_idx*2 +: 2];

  // ----------------------------------------------------------------
  // Control register and interrupts
  // ----------------------------------------------------------------
  wire [3:0] ev;                    // One-cycle events
  assign ev[`PSSA_IRQ_UD]    = take & ud;
  assign ev[`PSSA_IRQ_NUM]   = take & num_f;
  assign ev[`PSSA_IRQ_MEM]   = take & mem_f;
  assign ev[`PSSA_IRQ_EMPTY] = empty_ret;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg   <= `PSSA_CTRL_RESET;
      irq_st_reg <= 4'h0;
      irq_en_reg <= 4'h0;
    end else begin
      if (bus_wr_reg & (bus_addr_reg == `PSSA_OFF_CTRL)) begin
        ctrl_reg <= hwdata;
      end
      if (bus_wr_reg & (bus_addr_reg == `PSSA_OFF_IRQ_EN)) begin
        irq_en_reg <= hwdata[3:0];
      end
      // Event set wins over write-one-to-clear
      if (bus_wr_reg & (bus_addr_reg == `PSSA_OFF_IRQ_CLR)) begin
        irq_st_reg <= (irq_st_reg & ~hwdata[3:0]) | ev;
      end else begin
        irq_st_reg <= irq_st_reg | ev;
      end
    end
  end

  assign irq = |(irq_st_reg & irq_en_reg);

  // ----------------------------------------------------------------
  // Read data mux
  // ----------------------------------------------------------------
  always @* begin
    hrdata = 32'h00000000;
    if (bus_rd_reg) begin
      if (bus_addr_reg == `PSSA_OFF_CTRL) begin
        hrdata = ctrl_reg;
      end else if (bus_addr_reg == `PSSA_OFF_STATUS) begin
        hrdata = {28'h0000000, last_simd_reg, fp_error_pin, state_reg, pend_reg};
      end else if (bus_addr_reg == `PSSA_OFF_TAGW) begin
        hrdata = {16'h0000, tagw};
      end else if (bus_addr_reg == `PSSA_OFF_FPSW) begin
        hrdata = {18'h00000, top_reg, 5'h00, fpsw_lo_reg};
      end else if (bus_addr_reg == `PSSA_OFF_IRQ_STAT) begin
        hrdata = {28'h0000000, irq_st_reg};
      end else if (bus_addr_reg == `PSSA_OFF_IRQ_EN) begin
        hrdata = {28'h0000000, irq_en_reg};
      end else if (bus_addr_reg == `PSSA_OFF_FEATURE) begin
        hrdata = {8'h00, (HAS_SIMD != 0), 23'h000000};
      end else begin
        hrdata = 32'h00000000;
      end
    end
  end
endmodule

// ---- tb/pssa_top_asserts.sv ----
// Concurrent checks on the op, fault and storage ports of pssa_top.
// Assumes one clock, async active-low reset, bound by the bind below.
`timescale 1ns/100ps
`include "pssa_regs.vh"
module pssa_chk #(
  parameter HAS_QUERY = 1,                // Query op present
  parameter HAS_SIMD  = 1                 // SIMD present
) (
  input wire        hclk,                 // Clock
  input wire        hresetn,              // Reset, active low
  input wire        op_valid,             // Op presented
  input wire [2:0]  op_kind,              // Op class
  input wire [2:0]  op_dst,               // Destination
  input wire        op_wr_dst,            // Writes destination
  input wire [79:0] op_data,              // Op data
  input wire [31:0] op_leaf,              // Query leaf
  input wire        op_supported,         // Opcode known
  input wire        op_mem_fault,         // Address fault
  input wire        op_ready,             // Op taken
  input wire [2:0]  op_fault,             // Fault code
  input wire [7:0]  op_vector,            // Fault vector
  input wire [31:0] op_result,            // Query result
  input wire        handler_ret,          // Handler returned
  input wire [2:0]  save_idx,             // Save index
  input wire [79:0] save_data,            // Stored register
  input wire [1:0]  save_tag,             // Stored tag
  input wire        fp_error_pin          // Numeric error pin
);
  // ------------------------------------------------------------
  // Helpers and properties
  // ------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire        take = op_valid && op_ready;   // Op accepted this edge
  wire [63:0] lo   = op_data[63:0];           // SIMD payload
  wire        ok   = op_fault == `PSSA_FLT_NONE;

  a_unsup_fault: assert property (take && op_kind <= 3'h1 && !op_supported
    |=> op_fault == `PSSA_FLT_UD) else $error("unknown opcode did not fault");
  a_simd_valid: assert property (take && op_kind == 3'h0 ##1 ok && $stable(save_idx)
    |-> save_tag == `PSSA_TAG_VALID) else $error("SIMD op left a tag not valid");
  a_empty_tags: assert property (take && op_kind == 3'h1 ##1 ok && $stable(save_idx)
    |-> save_tag == `PSSA_TAG_EMPTY) else $error("empty op left a tag set");
  a_exp_ones: assert property (take && op_kind == 3'h0 && op_wr_dst && op_dst == save_idx
    ##1 ok && $stable(save_idx) |-> save_data == {`PSSA_EXP_ONES, $past(lo)})
    else $error("SIMD write not aliased with ones exponent");
  a_num_report: assert property (take ##1 op_fault == `PSSA_FLT_NUMERIC
    |-> op_vector == `PSSA_NUM_VECTOR && fp_error_pin) else $error("numeric report wrong");
  a_pin_holds: assert property (fp_error_pin && !handler_ret |=> fp_error_pin)
    else $error("error pin dropped early");
  a_wait_refuse: assert property (fp_error_pin |-> !op_ready)
    else $error("op accepted while handler runs");
  a_ret_release: assert property (fp_error_pin && handler_ret |=> !fp_error_pin)
    else $error("error pin held after handler return");
  a_fault_stands: assert property (!take |=> $stable(op_fault))
    else $error("fault code moved without an op");
  a_query_flag: assert property (take && op_kind == 3'h2 && !op_mem_fault
    && HAS_QUERY != 0 && op_leaf == `PSSA_FEAT_LEAF |=> ok && op_result[23] == (HAS_SIMD != 0))
    else $error("query flag wrong");
  a_float_plain: assert property (take && op_kind == 3'h3 && op_supported && !op_mem_fault
    |=> ok) else $error("float write faulted");

  c_empty: cover property (take && op_kind == 3'h1);
  c_handler: cover property (fp_error_pin && handler_ret);
  c_query: cover property (take && op_kind == 3'h2);
endmodule

bind pssa_top pssa_chk #(.HAS_QUERY(HAS_QUERY), .HAS_SIMD(HAS_SIMD)) i_chk (.hclk, .hresetn,
  .op_valid, .op_kind, .op_dst, .op_wr_dst, .op_data, .op_leaf, .op_supported, .op_mem_fault,
  .op_ready, .op_fault, .op_vector, .op_result, .handler_ret, .save_idx, .save_data,
  .save_tag, .fp_error_pin);

// ---- tb/testbench.sv ----
// Self-checking bench for the SIMD / float state alias block.
// Assumes pssa_regs.vh on the include path and the checker bound.
`timescale 1ns/100ps
`include "pssa_regs.vh"
module testbench;
  // ------------------------------------------------------------
  // Signals and instance
  // ------------------------------------------------------------
  reg         hclk = 1'h0;             // 25 MHz clock
  reg         hresetn = 1'h0;          // Reset, active low
  reg  [7:0]  haddr = 8'h00;           // Bus address
  reg  [1:0]  htrans = 2'h0;           // Transfer type
  reg         hwrite = 1'h0;           // Write strobe
  reg  [31:0] hwdata = 32'h00000000;   // Write data
  reg         op_valid = 1'h0;         // Op presented
  reg  [2:0]  op_kind = 3'h0;          // Op class
  reg  [2:0]  op_dst = 3'h0;           // Destination
  reg  [79:0] op_data = 80'h0;         // Op data
  reg         op_supported = 1'h1;     // Opcode known
  reg         op_mem_fault = 1'h0;     // Address fault
  reg         handler_ret = 1'h0;      // Handler return pulse
  reg  [2:0]  save_idx = 3'h0;         // Storage read index
  wire [31:0] hrdata;                  // Read data
  wire        hreadyout;               // Bus ready
  wire        op_ready;                // Op taken
  wire [2:0]  op_fault;                // Fault code
  wire [7:0]  op_vector;               // Fault vector
  wire [31:0] op_result;               // Query result
  wire [79:0] save_data;               // Stored register
  wire [1:0]  save_tag;                // Stored tag
  wire        fp_error_pin;            // Numeric error pin
  wire        irq;                     // Interrupt
  integer     mismatches = 0;          // Failed checks
  integer     compares = 0;            // Checks made
  reg  [31:0] rd;                      // Last read word
  localparam [79:0] SV = 80'h0000A5A55A5A0F0FF0F0;  // SIMD payload
  localparam [79:0] FV = 80'hC0011111222233334444;  // Float payload

  pssa_top i_dut (.hclk, .hresetn, .hsel(1'h1), .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .op_valid, .op_kind, .op_dst,
    .op_wr_dst(1'h1), .op_data, .op_leaf(32'h00000001), .op_supported, .op_mem_fault,
    .op_ready, .op_fault, .op_vector, .op_result, .handler_ret, .save_idx, .save_data,
    .save_tag, .fp_error_pin, .irq);

  always #20 hclk = ~hclk;

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task chk(input [8*6:1] nm, input [79:0] exp, input [79:0] got);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  // One AHB single transfer, read word left in rd
  task bus(input wr, input [7:0] a, input [31:0] d);
    begin
      @(posedge hclk);
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hreadyout !== 1'h1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'h1) @(posedge hclk);
      rd = hrdata;
      #1;
    end
  endtask
  // Present one op and hold it until taken
  task op(input [2:0] k, input [2:0] dst, input [79:0] v, input s, input m);
    begin
      @(posedge hclk);
      op_kind <= k;
      op_dst <= dst;
      op_data <= v;
      op_supported <= s;
      op_mem_fault <= m;
      op_valid <= 1'h1;
      @(posedge hclk);
      while (op_ready !== 1'h1) @(posedge hclk);
      op_valid <= 1'h0;
      #1;
    end
  endtask
  task look(input [2:0] i);
    begin
      @(posedge hclk);
      save_idx <= i;
      #1;
    end
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_reset;
    begin
      bus(0, `PSSA_OFF_TAGW, 0);    chk("tagw", 16'hFFFF, rd);
      bus(0, `PSSA_OFF_FEATURE, 0); chk("feat", 32'h00800000, rd);
      bus(1, 8'h40, 32'hFFFFFFFF);  bus(0, 8'h40, 0); chk("unmap", 0, rd);
    end
  endtask
  task t_simd;
    begin
      op(3'h3, 3'h5, FV, 1, 0);
      bus(1, `PSSA_OFF_FPSW, 32'h00002800); bus(0, `PSSA_OFF_FPSW, 0);
      chk("top5", 5, rd[13:11]); look(3'h2);
      op(3'h0, 3'h2, SV, 1, 0); chk("fault", `PSSA_FLT_NONE, op_fault);
      bus(0, `PSSA_OFF_TAGW, 0); chk("tagw", 0, rd);
      bus(0, `PSSA_OFF_FPSW, 0); chk("top", 0, rd[13:11]);
      look(3'h2); chk("alias", {16'hFFFF, SV[63:0]}, save_data);
      look(3'h5); chk("other", FV, save_data);
      op(3'h4, 3'h0, 0, 1, 0); chk("save", FV, save_data);
    end
  endtask
  task t_empty_irq;
    begin
      bus(1, `PSSA_OFF_IRQ_EN, 8);
      op(3'h1, 3'h0, 0, 1, 0);
      bus(0, `PSSA_OFF_TAGW, 0); chk("tagw", 16'hFFFF, rd);
      look(3'h2); chk("keep", {16'hFFFF, SV[63:0]}, save_data);
      chk("irq", 1, irq);
      bus(1, `PSSA_OFF_IRQ_EN, 0); chk("mask", 0, irq);
      bus(1, `PSSA_OFF_IRQ_EN, 8); bus(1, `PSSA_OFF_IRQ_CLR, 8); chk("clr", 0, irq);
      bus(0, `PSSA_OFF_IRQ_STAT, 0); chk("stat", 0, rd);
    end
  endtask
  task t_float;
    begin
      op(3'h3, 3'h1, FV, 1, 0); look(3'h1); chk("float", FV, save_data);
      chk("tag", 2'h0, save_tag);
      bus(0, `PSSA_OFF_TAGW, 0); chk("tagw", 16'hFFF3, rd);
    end
  endtask
  task t_faults;
    begin
      op(3'h0, 3'h3, SV, 0, 0); chk("unsup", `PSSA_FLT_UD, op_fault);
      bus(0, `PSSA_OFF_TAGW, 0); chk("tagw", 16'hFFF3, rd);
      bus(1, `PSSA_OFF_CTRL, 4);
      op(3'h0, 3'h3, SV, 1, 0); chk("emul", `PSSA_FLT_UD, op_fault);
      bus(1, `PSSA_OFF_CTRL, 0);
      op(3'h0, 3'h3, SV, 1, 1); chk("mem", `PSSA_FLT_MEM, op_fault);
      bus(0, `PSSA_OFF_IRQ_STAT, 0); chk("stat", 5, rd);
      op(3'h2, 3'h0, 0, 1, 0); chk("query", 1, op_result[23]);
    end
  endtask
  task t_numeric;
    begin
      bus(1, `PSSA_OFF_PEND_SET, 1);
      op(3'h0, 3'h4, SV, 1, 0); chk("num", `PSSA_FLT_NUMERIC, op_fault);
      chk("vec", 8'h10, op_vector); chk("pin", 1, fp_error_pin);
      fork
        op(3'h0, 3'h4, SV, 1, 0);
        begin
          @(posedge hclk);
          #1;
          chk("hold", 0, op_ready);
          repeat (2) @(posedge hclk);
          handler_ret <= 1'h1;
          @(posedge hclk);
          handler_ret <= 1'h0;
        end
      join
      chk("done", `PSSA_FLT_NONE, op_fault); chk("pin", 0, fp_error_pin);
      look(3'h4); chk("res", {16'hFFFF, SV[63:0]}, save_data);
    end
  endtask

  // ------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ------------------------------------------------------------
  task finish_test;
    begin
      $display("Checks %0d, mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'h1;
    t_reset;
    t_simd;
    t_empty_irq;
    t_float;
    t_faults;
    t_numeric;
    finish_test;
  end
  initial begin
    #100000;
    mismatches = mismatches + 1;
    finish_test;
  end
endmodule
